// ==== rtl/sar_converter_pkg.sv ====
// Constants, types and helper functions of the converter sequencer
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package sar_converter_pkg;

	// ------------------------------------------------------------
	// Register map (word index, byte address is four times it)
	// ------------------------------------------------------------
	localparam int            ADDR_W          = 6;
	localparam logic [3:0]    IDX_RESULT_LOW  = 4'h4;
	localparam logic [3:0]    IDX_RESULT_HIGH = 4'h5;
	localparam logic [3:0]    IDX_CTRL_A      = 4'h6;
	localparam logic [3:0]    IDX_INPUT_SEL   = 4'h7;
	localparam int            CA_ENABLE       = 7;
	localparam int            CA_START        = 6;
	localparam int            CA_AUTO         = 5;
	localparam int            CA_DONE         = 4;
	localparam int            CA_IRQ_EN       = 3;
	localparam int            CA_FREE         = 0;
	localparam int            IS_W            = 11;
	localparam logic [10:0]   IS_RESET        = 11'h000;

	// ------------------------------------------------------------
	// Conversion and timing
	// ------------------------------------------------------------
	localparam int            RESULT_W        = 10;
	localparam logic [9:0]    FULL_SCALE      = 10'h3FF;
	localparam logic [9:0]    MSB_TRIAL       = 10'h200;
	localparam int            SAMPLE_TICKS    = 2;
	localparam int            SYS_CLK_HZ      = 125_000_000;
	localparam int            CONV_CLK_HZ     = 1_000_000;
	localparam int            CONV_DIV        = SYS_CLK_HZ / CONV_CLK_HZ;
	localparam logic [5:0]    LAST_SINGLE     = 6'h0A;
	localparam logic [5:0]    FIRST_SPECIAL   = 6'h1E;

	typedef enum logic [1:0] {
		CS_IDLE    = 2'b00,
		CS_SAMPLE  = 2'b01,
		CS_CONVERT = 2'b11,
		CS_FINISH  = 2'b10
	} conv_state_t;

	typedef enum logic [2:0] {
		REF_SUPPLY   = 3'h0,
		REF_EXTERNAL = 3'h1,
		REF_INT_1V1  = 3'h2,
		REF_INT_2V56 = 3'h4,
		REF_INT_2V56_DECOUPLED = 3'h5
	} ref_t;

	typedef enum logic [1:0] {
		GAIN_1X  = 2'h0,
		GAIN_8X  = 2'h1,
		GAIN_20X = 2'h2,
		GAIN_32X = 2'h3
	} gain_t;

	// Input select register image: bit 10 gain, 9 left adjust, 8:6 reference, 5:0 channel
	typedef struct packed {
		logic       gain_hi;
		logic       left_adj;
		logic [2:0] ref_sel;
		logic [5:0] chan;
	} sel_t;

	function automatic logic is_single_ended(input logic [5:0] chan);
		is_single_ended = (chan <= LAST_SINGLE);
	endfunction : is_single_ended

	function automatic logic int_ref_on(input logic [2:0] ref_sel);
		int_ref_on = (ref_sel == REF_INT_1V1) || (ref_sel == REF_INT_2V56) ||
			(ref_sel == REF_INT_2V56_DECOUPLED);
	endfunction : int_ref_on

	function automatic logic [1:0] gain_of(input sel_t sel);
		logic high;
		high = ~sel.chan[0];
		if (is_single_ended(sel.chan) || sel.chan >= FIRST_SPECIAL && sel.chan < 6'h20)
			gain_of = GAIN_1X;
		else
			gain_of = {high, sel.gain_hi};
	endfunction : gain_of

	function automatic logic [7:0] format_result(input logic [9:0] res, input logic left,
		input logic high);
		if (left)
			format_result = high ? res[9:2] : {res[1:0], 6'h00};
		else
			format_result = high ? {6'h00, res[9:8]} : res[7:0];
	endfunction : format_result

endpackage : sar_converter_pkg

// ==== rtl/conv_clock_div.sv ====
// Converter clock divider: one tick pulse per converter clock rising edge
`timescale 1ns/1ps
module conv_clock_div #(
	parameter int DIV = 125
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Control and tick
	input  wire logic run,
	output logic      tick
);
	logic [15:0] cnt_r;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b || !run) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b0;
		end else if (cnt_r == 16'(DIV - 1)) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick  <= 1'b0;
		end
	end

endmodule : conv_clock_div

// ==== rtl/sar_engine.sv ====
// Successive approximation sequencer: sample, ten bit decisions, finish
`timescale 1ns/1ps
module sar_engine
	import sar_converter_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Control
	input  wire logic        tick,
	input  wire logic        start,
	input  wire logic        abort,
	input  wire logic        comp,
	// Status and analog drive
	output conv_state_t      state,
	output logic             lock,
	output logic             sample,
	output logic [9:0]       trial,
	output logic [9:0]       result,
	output logic             done
);
	logic [3:0] idx_r;
	logic [1:0] scnt_r;
	logic [9:0] kept;

	always_comb begin
		kept = trial;
		if (!comp)
			kept[idx_r] = 1'b0;
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b || abort) begin
			state  <= CS_IDLE;
			lock   <= 1'b0;
			sample <= 1'b0;
			trial  <= 10'h000;
			idx_r  <= 4'h9;
			scnt_r <= 2'h0;
			done   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (tick) begin
				case (state)
					CS_IDLE: if (start) begin
						state  <= CS_SAMPLE;
						lock   <= 1'b1;
						sample <= 1'b1;
						scnt_r <= 2'h0;
					end
					CS_SAMPLE: begin
						scnt_r <= scnt_r + 2'h1;
						if (scnt_r == 2'(SAMPLE_TICKS - 1)) begin
							state  <= CS_CONVERT;
							sample <= 1'b0;
							trial  <= MSB_TRIAL;
							idx_r  <= 4'h9;
						end
					end
					CS_CONVERT: begin
						// Comparator high keeps the bit; above reference yields all ones
						if (idx_r == 4'h0) begin
							state <= CS_FINISH;
							lock  <= 1'b0;
							trial <= kept;
						end else begin
							trial              <= kept | (10'h001 << (idx_r - 4'h1));
							idx_r              <= idx_r - 4'h1;
						end
					end
					CS_FINISH: begin
						state  <= CS_IDLE;
						result <= trial;
						done   <= 1'b1;
					end
					default: state <= CS_IDLE;
				endcase
			end
		end
	end

endmodule : sar_engine

// ==== rtl/sar_converter_sequencer.sv ====
// Converter sequencer top: register slave, selection buffering, start control, results
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module sar_converter_sequencer
	import sar_converter_pkg::*;
#(
	parameter int DIV = CONV_DIV
) (
	// Clock and reset
	input  wire logic              MCLK,
	input  wire logic              RST_B,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	output logic [31:0]            AVS_READDATA,
	output logic                   AVS_WAITREQUEST,
	// Pins from outside
	input  wire logic              TRIG_IN,
	input  wire logic              COMP_IN,
	// Analog front-end control
	output logic [5:0]             CHANNEL_CODE,
	output logic [2:0]             REF_SEL,
	output logic [1:0]             GAIN_SEL,
	output logic                   SINGLE_ENDED,
	output logic                   INT_REF_ON,
	output logic                   SAMPLE_HOLD,
	output logic [9:0]             DAC_CODE,
	// Completion request
	output logic                   DONE_IRQ
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	sel_t        sel_stage_r;
	sel_t        sel_act_r;
	logic        en_r;
	logic        auto_r;
	logic        irq_en_r;
	logic        free_r;
	logic        start_r;
	logic        done_flag_r;
	logic        hold_r;
	logic [9:0]  result_r;
	logic        trig_s1_r;
	logic        trig_s2_r;
	logic        trig_s3_r;
	logic        comp_s1_r;
	logic        comp_s2_r;
	logic        trig_edge;
	logic        tick;
	logic        lock;
	logic        eng_done;
	logic [9:0]  eng_result;
	conv_state_t eng_state;
	logic        req;
	logic        ack;
	logic        wr_ack;
	logic        rd_ack;
	logic [3:0]  idx;
	logic [31:0] rd_nxt;
	logic        sw_start;
	logic        retrig;

	assign idx       = AVS_ADDRESS[5:2];
	assign req       = AVS_READ || AVS_WRITE;
	assign ack       = req && !AVS_WAITREQUEST;
	assign wr_ack    = ack && AVS_WRITE;
	assign rd_ack    = ack && AVS_READ;
	assign trig_edge = trig_s2_r && !trig_s3_r;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_s3_r <= 1'b0;
		end else begin
			trig_s1_r <= TRIG_IN;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			comp_s1_r <= 1'b0;
			comp_s2_r <= 1'b0;
		end else begin
			comp_s1_r <= COMP_IN;
			comp_s2_r <= comp_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Bus handshake: one wait cycle, then waitrequest low for one cycle
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			AVS_WAITREQUEST <= 1'b1;
		else if (req && AVS_WAITREQUEST)
			AVS_WAITREQUEST <= 1'b0;
		else
			AVS_WAITREQUEST <= 1'b1;
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (idx)
			IDX_RESULT_LOW:  rd_nxt[7:0] = format_result(result_r, sel_stage_r.left_adj,
				1'b0);
			IDX_RESULT_HIGH: rd_nxt[7:0] = format_result(result_r, sel_stage_r.left_adj,
				1'b1);
			IDX_CTRL_A: begin
				rd_nxt[CA_ENABLE] = en_r;
				rd_nxt[CA_START]  = start_r;
				rd_nxt[CA_AUTO]   = auto_r;
				rd_nxt[CA_DONE]   = done_flag_r;
				rd_nxt[CA_IRQ_EN] = irq_en_r;
				rd_nxt[CA_FREE]   = free_r;
			end
			IDX_INPUT_SEL:   rd_nxt[IS_W-1:0] = sel_stage_r;
			default:         rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			AVS_READDATA <= 32'h0000_0000;
		else if (AVS_READ && AVS_WAITREQUEST)
			AVS_READDATA <= rd_nxt;
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	assign sw_start = wr_ack && idx == IDX_CTRL_A && AVS_BYTEENABLE[0] &&
		AVS_WRITEDATA[CA_START] && AVS_WRITEDATA[CA_ENABLE];
	assign retrig   = en_r && auto_r && (free_r ? eng_done : trig_edge);

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			en_r     <= 1'b0;
			auto_r   <= 1'b0;
			irq_en_r <= 1'b0;
			free_r   <= 1'b0;
		end else if (wr_ack && idx == IDX_CTRL_A && AVS_BYTEENABLE[0]) begin
			en_r     <= AVS_WRITEDATA[CA_ENABLE];
			auto_r   <= AVS_WRITEDATA[CA_AUTO];
			irq_en_r <= AVS_WRITEDATA[CA_IRQ_EN];
			free_r   <= AVS_WRITEDATA[CA_FREE];
		end
	end

	// Start request stays set while the conversion runs; a new start wins over completion
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			start_r <= 1'b0;
		else if (sw_start || retrig)
			start_r <= 1'b1;
		else if (!en_r || eng_done)
			start_r <= 1'b0;
	end

	// Done flag: write one clears it, a completion in the same cycle wins
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			done_flag_r <= 1'b0;
		else if (eng_done)
			done_flag_r <= 1'b1;
		else if (wr_ack && idx == IDX_CTRL_A && AVS_BYTEENABLE[0] && AVS_WRITEDATA[CA_DONE])
			done_flag_r <= 1'b0;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			DONE_IRQ <= 1'b0;
		else
			DONE_IRQ <= done_flag_r && irq_en_r;
	end

	// ------------------------------------------------------------
	// Selection staging and active copy
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			sel_stage_r <= IS_RESET;
		else if (wr_ack && idx == IDX_INPUT_SEL) begin
			if (AVS_BYTEENABLE[0])
				sel_stage_r[7:0] <= AVS_WRITEDATA[7:0];
			if (AVS_BYTEENABLE[1])
				sel_stage_r[IS_W-1:8] <= AVS_WRITEDATA[IS_W-1:8];
		end
	end

	// Copy follows the stage whenever unlocked, so the next conversion sees the update
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			sel_act_r <= IS_RESET;
		else if (!lock)
			sel_act_r <= sel_stage_r;
	end

	assign CHANNEL_CODE = sel_act_r.chan;
	assign REF_SEL      = sel_act_r.ref_sel;

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			GAIN_SEL     <= GAIN_1X;
			SINGLE_ENDED <= 1'b1;
			INT_REF_ON   <= 1'b0;
		end else begin
			GAIN_SEL     <= gain_of(sel_act_r);
			SINGLE_ENDED <= is_single_ended(sel_act_r.chan);
			INT_REF_ON   <= int_ref_on(sel_act_r.ref_sel);
		end
	end

	// ------------------------------------------------------------
	// Converter clock and engine
	// ------------------------------------------------------------
	conv_clock_div #(
		.DIV   (DIV)
	) u_div (
		.clk   (MCLK),
		.rst_b (RST_B),
		.run   (en_r),
		.tick  (tick)
	);

	sar_engine u_eng (
		.clk    (MCLK),
		.rst_b  (RST_B),
		.tick   (tick),
		.start  (start_r),
		.abort  (!en_r),
		.comp   (comp_s2_r),
		.state  (eng_state),
		.lock   (lock),
		.sample (SAMPLE_HOLD),
		.trial  (DAC_CODE),
		.result (eng_result),
		.done   (eng_done)
	);

	// ------------------------------------------------------------
	// Result pair lock
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			hold_r <= 1'b0;
		else if (rd_ack && idx == IDX_RESULT_LOW)
			hold_r <= 1'b1;
		else if (rd_ack && idx == IDX_RESULT_HIGH)
			hold_r <= 1'b0;
	end

	// A result finished while the pair is held is dropped
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			result_r <= 10'h000;
		else if (eng_done && !hold_r)
			result_r <= eng_result;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	property p_copy_when_free;
		!lock |=> sel_act_r == $past(sel_stage_r);
	endproperty
	a_copy_when_free: assert property (p_copy_when_free) else $error("copy missed");

	property p_frozen;
		lock |=> $stable(sel_act_r);
	endproperty
	a_frozen: assert property (p_frozen) else $error("selection moved while locked");

	property p_finish_unlocked;
		eng_state == CS_FINISH |-> !lock;
	endproperty
	a_finish_unlocked: assert property (p_finish_unlocked) else $error("still locked");

	property p_start_on_tick;
		en_r && tick && start_r && eng_state == CS_IDLE |=> lock && SAMPLE_HOLD;
	endproperty
	a_start_on_tick: assert property (p_start_on_tick) else $error("start tick missed");

	// An enabling write with the start bit may set the start request in the same cycle
	property p_disabled_idle;
		!en_r && !sw_start |=> !lock && eng_state == CS_IDLE && !start_r;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("active when off");

	property p_pair_held;
		hold_r && !(rd_ack && idx == IDX_RESULT_HIGH) |=> $stable(result_r) && hold_r;
	endproperty
	a_pair_held: assert property (p_pair_held) else $error("held result changed");

	property p_done_flag;
		eng_done |=> done_flag_r ##1 (DONE_IRQ == irq_en_r || !$stable(irq_en_r));
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag or request wrong");

	property p_left_high;
		rd_ack && idx == IDX_RESULT_HIGH && sel_stage_r.left_adj && $stable(result_r) &&
			$stable(sel_stage_r) |-> AVS_READDATA == {24'h00_0000, result_r[9:2]};
	endproperty
	a_left_high: assert property (p_left_high) else $error("left high byte wrong");

	property p_right_high;
		rd_ack && idx == IDX_RESULT_HIGH && !sel_stage_r.left_adj && $stable(result_r) &&
			$stable(sel_stage_r) |-> AVS_READDATA == {30'h0000_0000, result_r[9:8]};
	endproperty
	a_right_high: assert property (p_right_high) else $error("right high byte wrong");

	property p_left_low;
		rd_ack && idx == IDX_RESULT_LOW && sel_stage_r.left_adj && $stable(result_r) &&
			$stable(sel_stage_r) |-> AVS_READDATA == {24'h00_0000, result_r[1:0], 6'h00};
	endproperty
	a_left_low: assert property (p_left_low) else $error("left low byte wrong");

	property p_right_low;
		rd_ack && idx == IDX_RESULT_LOW && !sel_stage_r.left_adj && $stable(result_r) &&
			$stable(sel_stage_r) |-> AVS_READDATA == {24'h00_0000, result_r[7:0]};
	endproperty
	a_right_low: assert property (p_right_low) else $error("right low byte wrong");

	property p_free_restart;
		eng_done && en_r && auto_r && free_r |=> start_r;
	endproperty
	a_free_restart: assert property (p_free_restart) else $error("no free restart");

	property p_trigger_start;
		trig_edge && en_r && auto_r && !free_r |=> start_r;
	endproperty
	a_trigger_start: assert property (p_trigger_start) else $error("trigger edge lost");

	property p_one_wait;
		req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer late");

endmodule : sar_converter_sequencer

// ==== verification/afe_model.sv ====
// Behavioural analog front end: input multiplexer, sample and hold, comparator
`timescale 1ns/1ps
module afe_model
	import sar_converter_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Front-end control from the sequencer
	input  wire logic [5:0] chan,
	input  wire logic       sample,
	input  wire logic [9:0] dac,
	// Comparator output
	output logic            comp
);
	logic [9:0] held = 10'h000;

	// ----------------------------------------------------------------
	// Input levels
	// ----------------------------------------------------------------
	// Channel ten is driven above the reference, so it saturates
	function automatic logic [9:0] level_of(input logic [5:0] c);
		level_of = (c == 6'h0A) ? FULL_SCALE : {c[3:0], 6'h2B};
	endfunction : level_of

	// ----------------------------------------------------------------
	// Sample and hold, comparator
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (sample)
			held <= level_of(chan);
	end

	assign comp = (held >= dac);
endmodule : afe_model

// ==== verification/sar_converter_sequencer_tb.sv ====
// Self-checking testbench of the converter sequencer
`timescale 1ns/1ps
module sar_converter_sequencer_tb
	import sar_converter_pkg::*;
();
	localparam int DIV_TB = 8;
	localparam int LIMIT  = 20000;

	logic              MCLK;
	logic              RST_B;
	logic [ADDR_W-1:0] AVS_ADDRESS;
	logic              AVS_READ;
	logic              AVS_WRITE;
	logic [31:0]       AVS_WRITEDATA;
	logic [3:0]        AVS_BYTEENABLE;
	logic [31:0]       AVS_READDATA;
	logic              AVS_WAITREQUEST;
	logic              TRIG_IN;
	logic              COMP_IN;
	logic [5:0]        CHANNEL_CODE;
	logic [2:0]        REF_SEL;
	logic [1:0]        GAIN_SEL;
	logic              SINGLE_ENDED;
	logic              INT_REF_ON;
	logic              SAMPLE_HOLD;
	logic [9:0]        DAC_CODE;
	logic              DONE_IRQ;
	int                err_total = 0;
	int                num_checks = 0;
	int                cycles = 0;

	// ----------------------------------------------------------------
	// Clock, design and front end
	// ----------------------------------------------------------------
	initial begin
		MCLK = 1'b0;
		forever #4 MCLK = ~MCLK;
	end

	sar_converter_sequencer #(.DIV(DIV_TB)) sar_converter_sequencer_i (
		.MCLK(MCLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .TRIG_IN(TRIG_IN), .COMP_IN(COMP_IN),
		.CHANNEL_CODE(CHANNEL_CODE), .REF_SEL(REF_SEL), .GAIN_SEL(GAIN_SEL),
		.SINGLE_ENDED(SINGLE_ENDED), .INT_REF_ON(INT_REF_ON), .SAMPLE_HOLD(SAMPLE_HOLD),
		.DAC_CODE(DAC_CODE), .DONE_IRQ(DONE_IRQ));

	afe_model afe_model_i (.clk(MCLK), .chan(CHANNEL_CODE), .sample(SAMPLE_HOLD),
		.dac(DAC_CODE), .comp(COMP_IN));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	always @(posedge MCLK) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus_write(input logic [3:0] idx, input logic [31:0] d);
		@(posedge MCLK);
		AVS_ADDRESS   <= {idx, 2'b00};
		AVS_WRITEDATA <= d;
		AVS_WRITE     <= 1'b1;
		do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE     <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [3:0] idx, output logic [31:0] d);
		@(posedge MCLK);
		AVS_ADDRESS <= {idx, 2'b00};
		AVS_READ    <= 1'b1;
		do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
		d = AVS_READDATA;
		AVS_READ    <= 1'b0;
	endtask : bus_read

	task automatic settle();
		repeat (3) @(posedge MCLK);
		#1;
	endtask : settle

	task automatic wait_sample(output int n);
		n = 0;
		while (SAMPLE_HOLD !== 1'b1 && n < 4 * DIV_TB) begin
			@(posedge MCLK);
			n++;
		end
	endtask : wait_sample

	task automatic wait_done();
		logic [31:0] d;
		int          n;
		n = 0;
		d = 32'h0;
		while (d[CA_DONE] !== 1'b1 && n < 200) begin
			bus_read(IDX_CTRL_A, d);
			n++;
		end
		chk(d[CA_DONE], 1'b1);
	endtask : wait_done

	task automatic chk_res(input logic [9:0] exp, input logic left);
		logic [31:0] lo;
		logic [31:0] hi;
		bus_read(IDX_RESULT_LOW, lo);
		bus_read(IDX_RESULT_HIGH, hi);
		chk(lo, left ? {24'h0, exp[1:0], 6'h00} : {24'h0, exp[7:0]});
		chk(hi, left ? {24'h0, exp[9:2]} : {30'h0, exp[9:8]});
	endtask : chk_res

	function automatic logic [31:0] sel_w(input logic g, input logic la,
		input logic [2:0] r, input logic [5:0] c);
		sel_w = {21'h0, g, la, r, c};
	endfunction : sel_w

	function automatic logic [9:0] lvl(input logic [5:0] c);
		lvl = (c == 6'h0A) ? FULL_SCALE : {c[3:0], 6'h2B};
	endfunction : lvl

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [5:0]  gc [4];
		int          n;
		gc = '{6'h1E, 6'h20, 6'h21, 6'h26};
		RST_B = 1'b0;
		AVS_ADDRESS = '0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'h3;
		TRIG_IN = 1'b0;
		repeat (20) @(posedge MCLK);
		RST_B <= 1'b1;
		@(posedge MCLK);
		#1;
		chk({AVS_WAITREQUEST, SAMPLE_HOLD, DONE_IRQ, CHANNEL_CODE}, 9'h100);
		bus_read(IDX_INPUT_SEL, d);
		chk(d, 32'h0);
		bus_read(IDX_CTRL_A, d);
		chk(d, 32'h0);
		bus_write(4'h0, 32'hFF);
		bus_read(4'h0, d);
		chk(d, 32'h0);
		// Idle copying of channel and reference, decoded outputs
		for (int i = 0; i < 12; i++) begin
			bus_write(IDX_INPUT_SEL, sel_w(1'b0, 1'b0, i[2:0], i[5:0]));
			settle();
			chk(CHANNEL_CODE, i[5:0]);
			chk(SINGLE_ENDED, i <= 10);
			chk(REF_SEL, i[2:0]);
			chk(INT_REF_ON, i[2:0] == 3'h2 || i[2:0] == 3'h4 || i[2:0] == 3'h5);
		end
		for (int k = 0; k < 4; k++) begin
			for (int g = 0; g < 2; g++) begin
				bus_write(IDX_INPUT_SEL, sel_w(g[0], 1'b0, 3'h0, gc[k]));
				settle();
				chk(GAIN_SEL, gc[k] < 6'h20 ? 2'h0 : {~gc[k][0], g[0]});
			end
		end
		bus_read(IDX_INPUT_SEL, d);
		chk(d, sel_w(1'b1, 1'b0, 3'h0, 6'h26));
		// Start without enable is ignored
		bus_write(IDX_CTRL_A, 32'h40);
		wait_sample(n);
		chk(n, 4 * DIV_TB);
		// First result after the reference change is thrown away
		bus_write(IDX_CTRL_A, 32'hC0);
		wait_done();
		// Single conversion, reselect during it
		bus_write(IDX_INPUT_SEL, sel_w(1'b0, 1'b0, 3'h0, 6'h03));
		bus_write(IDX_CTRL_A, 32'hD8);
		wait_sample(n);
		chk(n <= DIV_TB + 3, 1'b1);
		bus_write(IDX_INPUT_SEL, sel_w(1'b0, 1'b0, 3'h0, 6'h05));
		settle();
		chk(CHANNEL_CODE, 6'h03);
		wait_done();
		chk(DONE_IRQ, 1'b1);
		chk(CHANNEL_CODE, 6'h05);
		chk_res(lvl(6'h03), 1'b0);
		bus_write(IDX_CTRL_A, 32'h98);
		settle();
		chk(DONE_IRQ, 1'b0);
		// Low read holds the pair until high is read
		bus_read(IDX_RESULT_LOW, d);
		chk(d, {24'h0, 8'(lvl(6'h03))});
		bus_write(IDX_CTRL_A, 32'hC0);
		wait_done();
		// Low again while held, then high releases the pair
		bus_read(IDX_RESULT_LOW, d);
		chk(d, {24'h0, 8'(lvl(6'h03))});
		bus_read(IDX_RESULT_HIGH, d);
		chk(d, {30'h0, 2'(lvl(6'h03) >> 8)});
		// Left adjusted full-scale result
		bus_write(IDX_INPUT_SEL, sel_w(1'b0, 1'b1, 3'h0, 6'h0A));
		bus_write(IDX_CTRL_A, 32'hD0);
		wait_done();
		chk_res(FULL_SCALE, 1'b1);
		// Trigger pin start
		bus_write(IDX_INPUT_SEL, sel_w(1'b0, 1'b0, 3'h0, 6'h01));
		bus_write(IDX_CTRL_A, 32'hB0);
		TRIG_IN <= 1'b1;
		repeat (3) @(posedge MCLK);
		TRIG_IN <= 1'b0;
		wait_done();
		chk_res(lvl(6'h01), 1'b0);
		// Free running: a change after the first result lands one later
		bus_write(IDX_INPUT_SEL, sel_w(1'b0, 1'b0, 3'h0, 6'h02));
		bus_write(IDX_CTRL_A, 32'hF1);
		wait_done();
		wait_sample(n);
		bus_write(IDX_INPUT_SEL, sel_w(1'b0, 1'b0, 3'h0, 6'h04));
		bus_write(IDX_CTRL_A, 32'hB1);
		wait_done();
		chk_res(lvl(6'h02), 1'b0);
		bus_write(IDX_CTRL_A, 32'hB1);
		wait_done();
		chk_res(lvl(6'h04), 1'b0);
		bus_write(IDX_CTRL_A, 32'h0);
		test_done();
	end
endmodule : sar_converter_sequencer_tb
